// ---- amsr_dev_end.sv ----
// Flash device end: addressing mode, software reset and status write gate.
// Behaviour
// - Instruction B7h enters four-byte addressing, no enable.
// - Hard reset, soft reset, power cycle leave it.
// - Soft reset only on 66h then 99h.
// - Reset instructions use current one, two, four lanes.
// - Host exits continuous quad read before reset.
// - Status one written only after write enable 06h.
// - Table bytes 3Ch-3Fh read F0h 30h F8h A1h.
// - Next dword: byte 40h 6Bh, bits 31:20 ones.
// - Eight clocks of Fh end continuous quad read.
`timescale 1ns/10ps
module amsr_dev_end
  import amsr_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Link to the host.
  amsr_link_if.dev link,
  // Operating mode and continuous read entry from the array logic.
  input wire amsr_width_t lane_mode,
  input wire logic xip_enter,
  // Device state.
  output logic addr4_o,
  output logic wel_o,
  output logic [7:0] status1_o,
  output logic xip_o,
  output logic soft_reset_o
);

  // ==========================================================================
  // Link input synchronisers
  // ==========================================================================
  typedef enum logic [2:0] {
    D_OPC, D_WDATA, D_ADDR, D_DUMMY, D_RDATA, D_SKIP, D_XIP
  } amsr_dstate_t;

  logic sck_s1, sck_s2, sck_d;    // Link clock, two stages and a history.
  logic cs_s1, cs_s2, cs_d;       // Frame select, likewise.
  logic [3:0] dq_s1, dq_s2;       // Lanes, two stages.

  // The link clock comes from the host, so it is sampled like any pin.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      {sck_s1, sck_s2, sck_d} <= 3'h0;
      {cs_s1, cs_s2, cs_d} <= 3'h7;
      dq_s1 <= 4'hf;
      dq_s2 <= 4'hf;
    end else begin
      {sck_s1, sck_s2, sck_d} <= {link.sck, sck_s1, sck_s2};
      {cs_s1, cs_s2, cs_d} <= {link.cs_n, cs_s1, cs_s2};
      dq_s1 <= link.quad_data_lines;
      dq_s2 <= dq_s1;
    end
  end

  // ==========================================================================
  // Edge and byte decoding
  // ==========================================================================
  amsr_dstate_t st_r, st_nxt;     // Position within the frame.
  logic [3:0] cnt_r;              // Bits of the current byte so far.
  logic [7:0] sh_r;               // Byte being shifted in.
  logic [1:0] abyte_r;            // Address bytes received.
  logic [5:0] dcnt_r;             // Dummy clocks seen.
  logic [7:0] off_r;              // Table offset of the next byte out.
  logic [3:0] xcnt_r;             // Clocks in a continuous frame, held at eight.
  logic xbad_r;                   // A clock in that frame was not all ones.
  logic addr4_r, wel_r, arm_r, pend_r, xip_r, srst_r;
  logic [7:0] sr1_r;              // First status register.
  logic [3:0] ocnt_r;             // Bits left of the byte being sent.
  logic [7:0] osh_r;              // Byte being sent.
  logic [3:0] dq_o_r, dq_oe_r;    // Lane drive.

  wire rise = sck_s2 && !sck_d && !cs_s2;
  wire fall = !sck_s2 && sck_d && !cs_s2;
  wire fstart = !cs_s2 && cs_d;
  wire fend = cs_s2 && !cs_d;
  wire [3:0] nl = nlanes(lane_mode);
  wire [7:0] sh_in = shift_in(sh_r, dq_s2, lane_mode);
  wire byte_done = rise && (4'(cnt_r + nl) == BYTE_BITS);
  wire op_done = byte_done && st_r == D_OPC;
  wire is_4b = op_done && sh_in == OP_ENTER_4B;
  wire is_en = op_done && sh_in == OP_RST_EN;
  wire is_rst = op_done && sh_in == OP_RST && arm_r;
  wire is_wren = op_done && sh_in == OP_WREN;
  wire sr_done = byte_done && st_r == D_WDATA;
  wire addr_last = abyte_r == 2'(ADDR_BYTES - 2'h1);
  wire dummy_last = dcnt_r == 6'(DUMMY_CYC - 6'h01);
  // Eight clean all-ones clocks end the continuous read at frame end.
  wire xip_quit = fend && st_r == D_XIP && !xbad_r &&
    xcnt_r >= XIP_EXIT_CYC;
  wire do_reset = fend && pend_r;
  wire [7:0] out_byte = ocnt_r == 4'h0 ? param_byte(off_r) : osh_r;

  // ==========================================================================
  // Frame state
  // ==========================================================================
  // While in continuous read the frame carries no instruction, so an
  // instruction sent then is never decoded; the host must exit first.
  always_comb begin
    st_nxt = st_r;
    if (fstart) begin
      st_nxt = xip_r ? D_XIP : D_OPC;
    end else if (rise) begin
      unique case (st_r)
        D_OPC: begin
          if (byte_done) begin
            if (sh_in == OP_WRSR) begin
              st_nxt = D_WDATA;
            end else if (sh_in == OP_PARAM_RD) begin
              st_nxt = D_ADDR;
            end else begin
              st_nxt = D_SKIP;
            end
          end
        end
        D_WDATA: begin
          if (byte_done) begin
            st_nxt = D_SKIP;
          end
        end
        D_ADDR: begin
          if (byte_done && addr_last) begin
            st_nxt = D_DUMMY;
          end
        end
        D_DUMMY: begin
          if (dummy_last) begin
            st_nxt = D_RDATA;
          end
        end
        D_RDATA, D_SKIP, D_XIP: begin
          st_nxt = st_r;
        end
      endcase
    end
  end

  // Bit, byte and clock counters restart with each frame.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r <= D_OPC;
      {cnt_r, sh_r, abyte_r, dcnt_r} <= 20'h0;
      {off_r, xcnt_r, xbad_r} <= 13'h0;
    end else begin
      st_r <= st_nxt;
      if (fstart) begin
        {cnt_r, abyte_r, dcnt_r, xcnt_r, xbad_r} <= 17'h0;
      end else if (rise) begin
        cnt_r <= byte_done ? 4'h0 : 4'(cnt_r + nl);
        sh_r <= sh_in;
        if (st_r == D_ADDR && byte_done) begin
          abyte_r <= 2'(abyte_r + 2'h1);
          off_r <= sh_in;  // Only the low address byte selects the table.
        end
        if (st_r == D_DUMMY) begin
          dcnt_r <= 6'(dcnt_r + 6'h01);
        end
        if (st_r == D_XIP) begin
          if (xcnt_r != XIP_EXIT_CYC) begin
            xcnt_r <= 4'(xcnt_r + 4'h1);
          end
          xbad_r <= xbad_r || dq_s2 != XIP_EXIT_NIB;
        end
      end else if (fall && st_r == D_RDATA && ocnt_r == 4'h0) begin
        off_r <= 8'(off_r + 8'h01);
      end
    end
  end

  // ==========================================================================
  // Mode and status flags
  // ==========================================================================
  // Any decoded instruction other than a reset enable drops the arming, so
  // a reset only follows an enable with nothing in between.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      {addr4_r, wel_r, arm_r, pend_r, xip_r, srst_r} <= 6'h0;
      sr1_r <= 8'h00;
    end else begin
      srst_r <= do_reset;
      if (do_reset) begin
        {addr4_r, wel_r, arm_r, pend_r} <= 4'h0;
      end else begin
        if (is_4b) begin
          addr4_r <= 1'b1;
        end
        if (op_done) begin
          arm_r <= is_en;
          pend_r <= is_rst;
        end
        if (is_wren) begin
          wel_r <= 1'b1;
        end else if (sr_done) begin
          wel_r <= 1'b0;
        end
        if (sr_done && wel_r) begin
          sr1_r <= sh_in;
        end
      end
      // Entry wins over an exit or a reset seen in the same cycle.
      if (xip_enter) begin
        xip_r <= 1'b1;
      end else if (xip_quit || do_reset) begin
        xip_r <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Table read output
  // ==========================================================================
  // Bits change on the falling link edge so the host samples them settled;
  // the lanes are released once the synchronised frame select reads high.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      {ocnt_r, osh_r, dq_o_r, dq_oe_r} <= 20'h0;
    end else if (cs_s2) begin
      ocnt_r <= 4'h0;
      dq_oe_r <= 4'h0;
    end else if (fall && st_r == D_RDATA) begin
      dq_o_r <= place(out_byte[7:4], lane_mode, 1'b1);
      dq_oe_r <= place(4'hf, lane_mode, 1'b1);
      osh_r <= 8'(out_byte << nl);
      ocnt_r <= 4'(BYTE_BITS - nl) == 4'h0 ? 4'h0 :
        4'((ocnt_r == 4'h0 ? BYTE_BITS : ocnt_r) - nl);
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign link.dev_dq_o = dq_o_r;
  assign link.dev_dq_oe = dq_oe_r;
  assign addr4_o = addr4_r;
  assign wel_o = wel_r;
  assign status1_o = sr1_r;
  assign xip_o = xip_r;
  assign soft_reset_o = srst_r;

endmodule

// ---- amsr_host_end.sv ----
// Host controller end: frames instructions, reset pairs and exit patterns.
`timescale 1ns/10ps
module amsr_host_end
  import amsr_pkg::*;
#(
  parameter int SCK_HALF = SCK_HALF_DEF
)
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Link to the device.
  amsr_link_if.host link,
  // Request.
  input wire logic req_valid,
  input wire amsr_req_t req_kind,
  input wire logic [7:0] req_op,
  input wire logic [7:0] req_data,
  input wire logic [23:0] req_addr,
  input wire amsr_width_t lane_mode,
  input wire logic xip_possible,
  output logic req_ready,
  // Answer.
  output logic rsp_valid,
  output logic [7:0] rsp_data
);

  // ==========================================================================
  // Request planning
  // ==========================================================================
  typedef enum logic [2:0] {H_IDLE, H_LOAD, H_LOW, H_HIGH, H_GAP} amsr_hst_t;

  amsr_hst_t st_r;
  amsr_frame_t plan_r [3], plan_nxt [3];  // Frames of one request.
  logic [1:0] pn_r, pn_nxt, pi_r;         // Frame count and index.
  logic [15:0] div_r;                     // Half link clock divider.
  logic [31:0] sh_r;                      // Bits left to send.
  logic [5:0] cyc_r, ocyc_r, tot_r;       // Link clock position in frame.
  amsr_width_t w_r;
  logic rd_r, sck_r, cs_r, ready_r, rv_r;
  logic [3:0] dq_o_r, dq_oe_r, dq_s1, dq_s2;
  logic [7:0] rd_sh;

  // Write status is always preceded by its own write enable frame, and a
  // reset pair by the exit pattern when continuous read may be active.
  always_comb begin
    plan_nxt[0] = '{{OP_WREN, 24'h0}, OP_BITS, 1'b0, 1'b0};
    plan_nxt[1] = plan_nxt[0];
    plan_nxt[2] = plan_nxt[0];
    pn_nxt = 2'h1;
    unique case (req_kind)
      REQ_INSTR: plan_nxt[0] = '{{req_op, 24'h0}, OP_BITS, 1'b0, 1'b0};
      REQ_WRSR: begin
        plan_nxt[1] = '{{OP_WRSR, req_data, 16'h0}, OP_DATA_BITS, 1'b0,
          1'b0};
        pn_nxt = 2'h2;
      end
      REQ_PARAM: plan_nxt[0] = '{{OP_PARAM_RD, req_addr}, OP_ADDR_BITS,
        1'b1, 1'b0};
      REQ_SWRST: begin
        plan_nxt[0] = '{XIP_EXIT_PAT, XIP_EXIT_BITS, 1'b0, 1'b1};
        plan_nxt[1] = '{{OP_RST_EN, 24'h0}, OP_BITS, 1'b0, 1'b0};
        plan_nxt[2] = '{{OP_RST, 24'h0}, OP_BITS, 1'b0, 1'b0};
        pn_nxt = 2'h3;
        if (!xip_possible) begin
          plan_nxt[0] = plan_nxt[1];
          plan_nxt[1] = plan_nxt[2];
          pn_nxt = 2'h2;
        end
      end
      REQ_XIP_EXIT: plan_nxt[0] = '{XIP_EXIT_PAT, XIP_EXIT_BITS, 1'b0,
        1'b1};
      default: pn_nxt = 2'h1;
    endcase
  end

  // ==========================================================================
  // Link framing
  // ==========================================================================
  wire tick = div_r == 16'(SCK_HALF - 1);
  wire amsr_frame_t fr = plan_r[pi_r];
  // The exit pattern always goes on four lanes; all else at the mode width.
  wire amsr_width_t fw = fr.xit ? AMSR_W4 : lane_mode;
  wire [5:0] focyc = 6'(fr.bits >> lane_log(fw));
  wire [5:0] rdcyc = 6'(BYTE_BITS >> lane_log(fw));
  wire [5:0] cyc1 = 6'(cyc_r + 6'h01);
  wire [31:0] sh_next = 32'(sh_r << nlanes(w_r));
  wire [3:0] rx = w_r == AMSR_W1 ? {3'h0, dq_s2[1]} : dq_s2;

  // The device's lanes come back across its own timing, so resync them.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dq_s1 <= 4'hf;
      dq_s2 <= 4'hf;
      div_r <= 16'h0;
    end else begin
      dq_s1 <= link.quad_data_lines;
      dq_s2 <= dq_s1;
      div_r <= tick ? 16'h0 : 16'(div_r + 16'h1);
    end
  end

  // Lanes change with the falling link edge; reads sample just before rise.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r <= H_IDLE;
      {pn_r, pi_r, cyc_r, ocyc_r, tot_r} <= 22'h0;
      {sh_r, rd_sh, dq_o_r, dq_oe_r} <= 48'h0;
      w_r <= AMSR_W1;
      {rd_r, sck_r, cs_r, ready_r, rv_r} <= 5'h06;
      plan_r <= '{default: '0};
    end else begin
      rv_r <= 1'b0;
      unique case (st_r)
        H_IDLE: begin
          if (req_valid && ready_r) begin
            plan_r <= plan_nxt;
            pn_r <= pn_nxt;
            pi_r <= 2'h0;
            ready_r <= 1'b0;
            st_r <= H_LOAD;
          end
        end
        H_LOAD: begin
          if (tick) begin
            cs_r <= 1'b0;
            w_r <= fw;
            rd_r <= fr.rd;
            ocyc_r <= focyc;
            tot_r <= 6'(focyc + (fr.rd ? 6'(DUMMY_CYC + rdcyc) : 6'h0));
            cyc_r <= 6'h0;
            sh_r <= fr.sh;
            dq_o_r <= place(fr.sh[31:28], fw, 1'b0);
            dq_oe_r <= place(4'hf, fw, 1'b0);
            st_r <= H_LOW;
          end
        end
        H_LOW: begin
          if (tick) begin
            sck_r <= 1'b1;
            if (rd_r && cyc_r >= 6'(ocyc_r + DUMMY_CYC)) begin
              rd_sh <= shift_in(rd_sh, rx, w_r);
            end
            st_r <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (tick) begin
            sck_r <= 1'b0;
            cyc_r <= cyc1;
            sh_r <= sh_next;
            dq_o_r <= place(sh_next[31:28], w_r, 1'b0);
            dq_oe_r <= cyc1 < ocyc_r ? place(4'hf, w_r, 1'b0) : 4'h0;
            st_r <= cyc1 == tot_r ? H_GAP : H_LOW;
          end
        end
        H_GAP: begin
          // A full half clock with select high separates the frames.
          cs_r <= 1'b1;
          dq_oe_r <= 4'h0;
          if (tick && cs_r) begin
            if (2'(pi_r + 2'h1) < pn_r) begin
              pi_r <= 2'(pi_r + 2'h1);
              st_r <= H_LOAD;
            end else begin
              rv_r <= rd_r;
              ready_r <= 1'b1;
              st_r <= H_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign link.sck = sck_r;
  assign link.cs_n = cs_r;
  assign link.host_dq_o = dq_o_r;
  assign link.host_dq_oe = dq_oe_r;
  assign req_ready = ready_r;
  assign rsp_valid = rv_r;
  assign rsp_data = rd_sh;

endmodule

// ---- amsr_link_if.sv ----
// Link between the host controller end and the flash device end.
`timescale 1ns/10ps
interface amsr_link_if;
  logic sck;                    // Link clock, made by the host.
  logic cs_n;                   // Frame select, active low.
  logic [3:0] host_dq_o;        // Host lane values.
  logic [3:0] host_dq_oe;       // Host lane enables, high while driving.
  logic [3:0] dev_dq_o;         // Device lane values.
  logic [3:0] dev_dq_oe;        // Device lane enables, high while driving.
  logic [3:0] quad_data_lines;  // Resolved lane levels, pulled up when idle.

  // A lane nobody drives floats high, as the pull-ups make it.
  assign quad_data_lines = (dev_dq_oe & dev_dq_o) |
    (~dev_dq_oe & host_dq_oe & host_dq_o) | (~dev_dq_oe & ~host_dq_oe);

  modport host(output sck, cs_n, host_dq_o, host_dq_oe,
    input quad_data_lines);
  modport dev(input sck, cs_n, quad_data_lines,
    output dev_dq_o, dev_dq_oe);
endinterface

// ---- amsr_link_properties.sv ----
// Concurrent checks on the link and on the device state outputs.
`timescale 1ns/10ps
module amsr_link_properties (
  // Clock, reset and link.
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] host_dq_oe,
  input wire logic [3:0] dev_dq_oe,
  // Device state.
  input wire logic addr4_o,
  input wire logic wel_o,
  input wire logic [7:0] status1_o,
  input wire logic xip_o,
  input wire logic soft_reset_o
);
  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // A frame closes when the select returns high.
  sequence s_frame_end;
    $rose(cs_n);
  endsequence
  chk_sck_idle_low: assert property (cs_n |-> !sck)
    else $error("link clock high outside a frame");
  chk_host_lanes: assert property (host_dq_oe inside
    {4'h0, 4'h1, 4'h3, 4'hf})
    else $error("host lane enables not a legal width");
  chk_dev_lanes: assert property (dev_dq_oe inside
    {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("device lane enables not a legal width");
  chk_dev_release: assert property (s_frame_end |-> ##[0:4] !dev_dq_oe)
    else $error("device still drives after frame end");
  chk_reset_pulse: assert property (soft_reset_o |=> !soft_reset_o)
    else $error("soft reset longer than one cycle");
  chk_reset_idle: assert property (soft_reset_o |-> cs_n)
    else $error("soft reset inside a frame");
  chk_reset_clears: assert property (soft_reset_o |-> ##1 !addr4_o && !wel_o)
    else $error("soft reset left four-byte mode or enable");
  chk_addr4_rise: assert property ($rose(addr4_o) |-> !cs_n)
    else $error("four-byte mode set outside a frame");
  chk_status_gate: assert property ($changed(status1_o) |-> $past(wel_o))
    else $error("status written without enable");
  chk_xip_exit: assert property ($fell(xip_o) |-> cs_n)
    else $error("quad read ended inside a frame");
endmodule

// ---- amsr_pkg.sv ----
// Shared constants, types and helpers for the addressing and reset link.
package amsr_pkg;

  // ==========================================================================
  // Instruction codes
  // ==========================================================================
  localparam logic [7:0] OP_ENTER_4B = 8'hb7;  // Enter four-byte addressing.
  localparam logic [7:0] OP_RST_EN = 8'h66;    // Reset enable.
  localparam logic [7:0] OP_RST = 8'h99;       // Reset, only after enable.
  localparam logic [7:0] OP_WREN = 8'h06;      // Write enable.
  localparam logic [7:0] OP_WRSR = 8'h01;      // Write first status register.
  localparam logic [7:0] OP_PARAM_RD = 8'h5a;  // Parameter table read.

  // ==========================================================================
  // Parameter table contents
  // ==========================================================================
  // Field values of the reset and addressing dword, from bit 31 down.
  localparam logic [7:0] ENTER_4B_METHODS = 8'ha1;
  localparam logic [9:0] EXIT_4B_METHODS = 10'h3e0;
  localparam logic [5:0] SOFT_RST_METHODS = 6'h30;
  localparam logic RSV_BIT7 = 1'b1;
  localparam logic [6:0] SR1_WREN_METHODS = 7'h70;
  localparam logic [31:0] PARAM_RST_DW = {ENTER_4B_METHODS, EXIT_4B_METHODS,
    SOFT_RST_METHODS, RSV_BIT7, SR1_WREN_METHODS};
  localparam logic [7:0] PARAM_RST_OFF = 8'h3c;   // First byte of that dword.
  localparam logic [7:0] PARAM_NEXT_OFF = 8'h40;  // First byte of next dword.
  localparam logic [7:0] PARAM_NEXT_B2 = 8'h42;
  localparam logic [7:0] PARAM_NEXT_B3 = 8'h43;
  localparam logic [7:0] PARAM_NEXT_B0 = 8'h6b;
  localparam logic [11:0] PARAM_NEXT_RFU = 12'hfff;  // Bits 31:20, all ones.
  localparam logic [7:0] PARAM_FILL = 8'hff;         // Bytes not modelled.

  // ==========================================================================
  // Framing and timing
  // ==========================================================================
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] ADDR_BYTES = 2'h3;
  localparam logic [5:0] DUMMY_CYC = 6'h08;
  localparam logic [3:0] XIP_EXIT_CYC = 4'h8;   // Clocks of all-ones needed.
  localparam logic [3:0] XIP_EXIT_NIB = 4'hf;
  localparam logic [31:0] XIP_EXIT_PAT = 32'hffffffff;
  localparam logic [5:0] XIP_EXIT_BITS = 6'h20;  // Eight clocks on four lanes.
  localparam logic [5:0] OP_BITS = 6'h08;
  localparam logic [5:0] OP_DATA_BITS = 6'h10;
  localparam logic [5:0] OP_ADDR_BITS = 6'h20;
  localparam int SCK_HALF_DEF = 8;  // System clocks per half link clock.

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {AMSR_W1, AMSR_W2, AMSR_W4} amsr_width_t;
  typedef enum logic [2:0] {
    REQ_INSTR, REQ_WRSR, REQ_PARAM, REQ_SWRST, REQ_XIP_EXIT
  } amsr_req_t;
  typedef struct packed {
    logic [31:0] sh;    // Bits to send, first bit in bit 31.
    logic [5:0] bits;   // Number of bits to send.
    logic rd;           // Frame ends with dummy clocks and one read byte.
    logic xit;          // Frame is the all-ones exit pattern on four lanes.
  } amsr_frame_t;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Base-two log of the lane count.
  function automatic logic [1:0] lane_log(input amsr_width_t w);
    unique case (w)
      AMSR_W1: return 2'h0;
      AMSR_W2: return 2'h1;
      default: return 2'h2;
    endcase
  endfunction

  // Number of lanes used at a width.
  function automatic logic [3:0] nlanes(input amsr_width_t w);
    return 4'(4'h1 << lane_log(w));
  endfunction

  // Shift received lanes into a byte, lane 0 being the single-wire input.
  function automatic logic [7:0] shift_in(input logic [7:0] sh,
      input logic [3:0] dq, input amsr_width_t w);
    unique case (w)
      AMSR_W1: return {sh[6:0], dq[0]};
      AMSR_W2: return {sh[5:0], dq[1:0]};
      default: return {sh[3:0], dq};
    endcase
  endfunction

  // Place the top bits on the lanes; single-wire sends on lane 0 or 1.
  function automatic logic [3:0] place(input logic [3:0] top,
      input amsr_width_t w, input logic on_lane1);
    unique case (w)
      AMSR_W1: return on_lane1 ? {2'h0, top[3], 1'b0} : {3'h0, top[3]};
      AMSR_W2: return {2'h0, top[3:2]};
      default: return top;
    endcase
  endfunction

  // Byte of the parameter table at a byte offset.
  function automatic logic [7:0] param_byte(input logic [7:0] off);
    logic [7:0] rel;
    rel = off - PARAM_RST_OFF;
    if (off >= PARAM_RST_OFF && off < PARAM_NEXT_OFF) begin
      return PARAM_RST_DW[{rel[1:0], 3'h0} +: 8];
    end
    if (off == PARAM_NEXT_OFF) begin
      return PARAM_NEXT_B0;
    end
    if (off == PARAM_NEXT_B2) begin
      return {PARAM_NEXT_RFU[3:0], PARAM_FILL[3:0]};
    end
    if (off == PARAM_NEXT_B3) begin
      return PARAM_NEXT_RFU[11:4];
    end
    return PARAM_FILL;
  endfunction

endpackage

// ---- testbench.sv ----
// Bench joining the host end to the device end over the link.
`timescale 1ns/10ps
module testbench;
  import amsr_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  amsr_req_t req_kind = REQ_INSTR;
  logic [7:0] req_op = 8'h00;
  logic [7:0] req_data = 8'h00;
  amsr_width_t lane_mode = AMSR_W1;
  logic xip_possible = 1'b0;
  logic xip_enter = 1'b0;
  logic req_ready, rsp_valid, addr4_o, wel_o, xip_o, soft_reset_o;
  logic [7:0] rsp_data, status1_o, d;
  int fails = 0;
  int checked = 0;
  int resets = 0;
  int rsps = 0;
  amsr_link_if lnk();
  amsr_host_end #(.SCK_HALF(8)) u_amsr_host_end (.clk_sys(clk_sys),
    .nrst(nrst), .link(lnk), .req_valid(req_valid), .req_kind(req_kind),
    .req_op(req_op), .req_data(req_data), .req_addr({16'h0000, req_data}),
    .lane_mode(lane_mode), .xip_possible(xip_possible),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  amsr_dev_end u_amsr_dev_end (.clk_sys(clk_sys), .nrst(nrst), .link(lnk),
    .lane_mode(lane_mode), .xip_enter(xip_enter), .addr4_o(addr4_o),
    .wel_o(wel_o), .status1_o(status1_o), .xip_o(xip_o),
    .soft_reset_o(soft_reset_o));
  amsr_link_properties u_props (.clk_sys(clk_sys), .nrst(nrst),
    .sck(lnk.sck), .cs_n(lnk.cs_n), .host_dq_oe(lnk.host_dq_oe),
    .dev_dq_oe(lnk.dev_dq_oe), .addr4_o(addr4_o), .wel_o(wel_o),
    .status1_o(status1_o), .xip_o(xip_o), .soft_reset_o(soft_reset_o));
  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Expected table byte, with unlisted places reading as fill.
  function automatic logic [7:0] exp_byte(input logic [7:0] off);
    case (off)
      8'h3c: return 8'hf0;
      8'h3d: return 8'h30;
      8'h3e: return 8'hf8;
      8'h3f: return 8'ha1;
      8'h40: return 8'h6b;
      default: return 8'hff;
    endcase
  endfunction
  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  // Ready is read before the edge updates land, hence the extra edge.
  task automatic send(input amsr_req_t k, input logic [7:0] op, dat);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_kind <= k;
    req_op <= op;
    req_data <= dat;
    repeat (2) @(posedge clk_sys);
    req_valid <= 1'b0;
    while (req_ready !== 1'b1) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic print_verdict();
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========================================================================
  // Clock, pulse count, watchdog and tests
  // ==========================================================================
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (soft_reset_o === 1'b1) begin
      resets <= resets + 1;
    end
    if (rsp_valid === 1'b1) begin
      rsps <= rsps + 1;
    end
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    fails++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h310c));
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      lane_mode <= amsr_width_t'(i);
      send(REQ_INSTR, OP_ENTER_4B, 8'h00);
      check(addr4_o === 1'b1 && wel_o === 1'b0, "enter 4B");
      send(REQ_INSTR, OP_RST_EN, 8'h00);
      send(REQ_INSTR, OP_WREN, 8'h00);
      send(REQ_INSTR, OP_RST, 8'h00);
      check(addr4_o === 1'b1 && resets == i, "lone reset");
      send(REQ_SWRST, 8'h00, 8'h00);
      check(addr4_o === 1'b0 && resets == i + 1, "reset pair");
    end
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 8'hff : 8'($urandom);
      send(REQ_WRSR, 8'h00, d);
      check(status1_o === d && wel_o === 1'b0, "status write");
    end
    for (int o = 8'h3c; o < 8'h44; o++) begin
      lane_mode <= amsr_width_t'($urandom_range(2));
      send(REQ_PARAM, 8'h00, 8'(o));
      check(rsp_data === exp_byte(8'(o)), "table byte");
      check(rsps == o - 8'h3b, "table answer");
    end
    lane_mode <= AMSR_W4;
    xip_possible <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      xip_enter <= 1'b1;
      @(posedge clk_sys);
      xip_enter <= 1'b0;
      @(posedge clk_sys);
      check(xip_o === 1'b1, "quad entry");
      send(k ? REQ_SWRST : REQ_XIP_EXIT, 8'h00, 8'h00);
      check(xip_o === 1'b0 && resets == 3 + k, "quad exit");
    end
    print_verdict();
  end
endmodule
